// ---- rtl/fbg_frac_div.sv ----
// fractional divider: phase accumulator that emits one tick per bit period
`timescale 1ns/1ps
module fbg_frac_div #(
   parameter int SCALE_W = 3,
   parameter int FRAC_W = 6,
   parameter int ACC_W = 15
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire logic step_i,
   input wire logic [SCALE_W-1:0] scale_i,
   input wire logic [FRAC_W-1:0] frac_i,
   // result
   output logic tick_o
);

   logic [ACC_W-1:0] acc_q;
   logic [ACC_W-1:0] acc_d;
   logic [ACC_W-1:0] limit;
   logic [ACC_W-1:0] sum;
   logic tick_q;
   logic tick_d;

   // accumulator keeps the remainder, so the average rate is exact, not rounded
   always_comb begin
      limit = (ACC_W'(fbg_pkg::FRAC_OFFSET) + ACC_W'(frac_i)) << scale_i;
      sum = acc_q + ACC_W'(fbg_pkg::ACC_STEP);
      acc_d = acc_q;
      tick_d = 1'b0;
      if (!run_i) begin
         acc_d = '0;
      end else if (step_i) begin
         // limit is at least 64, so one subtraction suffices unless a register write lowers limit below acc_q
         if (sum >= limit) begin
            acc_d = sum - limit;
            tick_d = 1'b1;
         end else begin
            acc_d = sum;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         acc_q <= '0;
         tick_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         tick_q <= tick_d;
      end
   end

   assign tick_o = tick_q;

endmodule

// ---- rtl/fbg_pkg.sv ----
// package: register map, field layout and divider constants of the baud generator
package fbg_pkg;

   // register addresses on the special function register port
   localparam logic [7:0] FRAC_ADDR = 8'h9d;
   localparam logic [7:0] CTRL_ADDR = 8'h9e;

   // reset values of both registers
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] FRAC_RESET = 8'h00;

   // answer on a read of any other address
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // baud_control_reg field layout
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_SCALE_MSB = 2;
   localparam int CTRL_SCALE_LSB = 0;

   // baud_fraction_reg field layout
   localparam int FRAC_MSB = 5;
   localparam int FRAC_LSB = 0;

   // field widths
   localparam int SCALE_W = 3;
   localparam int FRAC_W = 6;

   // fractional stage: divisor is (fraction + 64) shifted by the binary scale
   localparam int FRAC_OFFSET = 64;
   // four phase units added per core step, so the tick period is 2^scale*(frac+64)/4
   localparam int ACC_STEP = 4;
   // wide enough for 127 << 7
   localparam int ACC_W = 15;

   // classic timer scheme: overflows per bit
   localparam int T1_DIV_NORM = 32;
   localparam int T1_DIV_DBL = 16;
   localparam int T2_DIV = 16;
   localparam int LEG_CNT_W = 5;

   // number of bit-rate directions (transmit, receive)
   localparam int NUM_DIR = 2;
   localparam int DIR_TX = 0;
   localparam int DIR_RX = 1;

   // register port request from the core
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } fbg_sfr_req_t;

   // inputs of the classic timer-based rate scheme
   typedef struct packed {
      logic t1_ovf;
      logic t2_ovf;
      logic rate_double;
      logic timer2_tx_clock_select;
      logic timer2_rx_clock_select;
   } fbg_legacy_t;

endpackage

// ---- rtl/fbg_top.sv ----
// top: baud generator registers, fractional generator and classic rate selection
`timescale 1ns/1ps
module fbg_top (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // core clock enable, one pulse per core clock
   input wire logic core_step_i,
   // register port
   input wire fbg_pkg::fbg_sfr_req_t sfr_i,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_ack_o,
   // classic timer scheme inputs
   input wire fbg_pkg::fbg_legacy_t legacy_i,
   // bit-rate ticks to the serial port
   output logic tx_baud_tick_o,
   output logic rx_baud_tick_o,
   // status
   output logic generator_enable_o
);

   // register state
   logic generator_enable_q;
   logic generator_enable_d;
   logic [fbg_pkg::SCALE_W-1:0] binary_scale_q;
   logic [fbg_pkg::SCALE_W-1:0] binary_scale_d;
   logic [fbg_pkg::FRAC_W-1:0] fraction_value_q;
   logic [fbg_pkg::FRAC_W-1:0] fraction_value_d;

   // read port state
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic ack_q;
   logic ack_d;

   // register images as seen by software
   logic [7:0] ctrl_image;
   logic [7:0] frac_image;

   // address decode and qualified strobes
   logic ctrl_sel;
   logic frac_sel;
   logic ctrl_wr;
   logic frac_wr;
   logic ctrl_rd;
   logic frac_rd;

   // generator output
   logic gen_tick;

   // per-direction tick outputs
   logic [fbg_pkg::NUM_DIR-1:0] tick_q;
   logic [fbg_pkg::NUM_DIR-1:0] tick_d;

   // classic tick per direction, before the source select
   logic [fbg_pkg::NUM_DIR-1:0] leg_tick;

   // register images: unimplemented bits read back as zero
   always_comb begin
      ctrl_image = fbg_pkg::CTRL_RESET;
      ctrl_image[fbg_pkg::CTRL_EN_BIT] = generator_enable_q;
      ctrl_image[fbg_pkg::CTRL_SCALE_MSB:fbg_pkg::CTRL_SCALE_LSB] = binary_scale_q;
      frac_image = fbg_pkg::FRAC_RESET;
      frac_image[fbg_pkg::FRAC_MSB:fbg_pkg::FRAC_LSB] = fraction_value_q;
   end

   // one comparator per register, so write and read paths always agree on the target
   always_comb begin
      ctrl_sel = (sfr_i.addr == fbg_pkg::CTRL_ADDR);
      frac_sel = (sfr_i.addr == fbg_pkg::FRAC_ADDR);
      ctrl_wr = sfr_i.wr && ctrl_sel;
      frac_wr = sfr_i.wr && frac_sel;
      ctrl_rd = sfr_i.rd && ctrl_sel;
      frac_rd = sfr_i.rd && frac_sel;
   end

   // register writes: whole bytes only, spare bits are dropped
   always_comb begin
      generator_enable_d = generator_enable_q;
      binary_scale_d = binary_scale_q;
      fraction_value_d = fraction_value_q;
      if (ctrl_wr) begin
         generator_enable_d = sfr_i.wdata[fbg_pkg::CTRL_EN_BIT];
         // code 7 is not blocked; it acts as a further doubling of the divisor
         binary_scale_d =
            sfr_i.wdata[fbg_pkg::CTRL_SCALE_MSB:fbg_pkg::CTRL_SCALE_LSB];
      end
      if (frac_wr) begin
         fraction_value_d = sfr_i.wdata[fbg_pkg::FRAC_MSB:fbg_pkg::FRAC_LSB];
      end
   end

   // registers come up at zero, generator off
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         generator_enable_q <= fbg_pkg::CTRL_RESET[fbg_pkg::CTRL_EN_BIT];
         binary_scale_q <=
            fbg_pkg::CTRL_RESET[fbg_pkg::CTRL_SCALE_MSB:fbg_pkg::CTRL_SCALE_LSB];
         fraction_value_q <= fbg_pkg::FRAC_RESET[fbg_pkg::FRAC_MSB:fbg_pkg::FRAC_LSB];
      end else begin
         generator_enable_q <= generator_enable_d;
         binary_scale_q <= binary_scale_d;
         fraction_value_q <= fraction_value_d;
      end
   end

   // read data and acknowledge, one cycle after the access
   always_comb begin
      rdata_d = fbg_pkg::UNMAPPED_READ;
      ack_d = 1'b0;
      // a read and a write in one cycle still give a single acknowledge
      if (ctrl_sel || frac_sel) begin
         ack_d = sfr_i.rd | sfr_i.wr;
      end
      if (ctrl_rd) begin
         rdata_d = ctrl_image;
      end
      if (frac_rd) begin
         rdata_d = frac_image;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_q <= fbg_pkg::UNMAPPED_READ;
         ack_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         ack_q <= ack_d;
      end
   end

   // fractional generator; held cleared while disabled so enabling starts a clean period
   fbg_frac_div #(
      .SCALE_W(fbg_pkg::SCALE_W),
      .FRAC_W(fbg_pkg::FRAC_W),
      .ACC_W(fbg_pkg::ACC_W)
   ) u_frac_div (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .run_i(generator_enable_q),
      .step_i(core_step_i),
      .scale_i(binary_scale_q),
      .frac_i(fraction_value_q),
      .tick_o(gen_tick)
   );

   // classic scheme per direction: overflow prescaler, then source select
   for (genvar d = 0; d < fbg_pkg::NUM_DIR; d++) begin : g_dir
      logic [fbg_pkg::LEG_CNT_W-1:0] cnt_q;
      logic [fbg_pkg::LEG_CNT_W-1:0] cnt_d;
      logic [fbg_pkg::LEG_CNT_W-1:0] last;
      logic use_t2;
      logic src;

      always_comb begin
         use_t2 = (d == fbg_pkg::DIR_TX) ? legacy_i.timer2_tx_clock_select
                                         : legacy_i.timer2_rx_clock_select;
         src = use_t2 ? legacy_i.t2_ovf : legacy_i.t1_ovf;
         // timer 2 always divides by 16; timer 1 by 32, or 16 when doubled
         if (use_t2) begin
            last = fbg_pkg::LEG_CNT_W'(fbg_pkg::T2_DIV - 1);
         end else if (legacy_i.rate_double) begin
            last = fbg_pkg::LEG_CNT_W'(fbg_pkg::T1_DIV_DBL - 1);
         end else begin
            last = fbg_pkg::LEG_CNT_W'(fbg_pkg::T1_DIV_NORM - 1);
         end
         // counters hold between overflows; only the selected timer advances them
         cnt_d = cnt_q;
         leg_tick[d] = 1'b0;
         if (generator_enable_q) begin
            // the classic path is idle, so a later switch back starts fresh
            cnt_d = '0;
         end else if (src) begin
            if (cnt_q >= last) begin
               cnt_d = '0;
               leg_tick[d] = 1'b1;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
      end

      always_ff @(posedge mclk_i) begin
         if (rst_i) begin
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_d;
         end
      end
   end

   // source select: generator wins whenever enabled, select and double inputs unused then
   always_comb begin
      tick_d = leg_tick;
      if (generator_enable_q) begin
         tick_d = {fbg_pkg::NUM_DIR{gen_tick}};
      end
   end

   // output ticks registered so the serial port sees clean one-cycle pulses
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tick_q <= '0;
      end else begin
         tick_q <= tick_d;
      end
   end

   // outputs straight from flip-flops
   assign tx_baud_tick_o = tick_q[fbg_pkg::DIR_TX];
   assign rx_baud_tick_o = tick_q[fbg_pkg::DIR_RX];
   assign sfr_rdata_o = rdata_q;
   assign sfr_ack_o = ack_q;
   assign generator_enable_o = generator_enable_q;

endmodule

// ---- verification/fbg_chk.sv ----
// checker: port assertions of the baud generator
`timescale 1ns/1ps
module fbg_chk (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // inputs
   input wire logic core_step_i,
   input wire fbg_pkg::fbg_sfr_req_t sfr_i,
   input wire fbg_pkg::fbg_legacy_t legacy_i,
   // outputs
   input wire logic [7:0] sfr_rdata_o,
   input wire logic sfr_ack_o,
   input wire logic tx_baud_tick_o,
   input wire logic rx_baud_tick_o,
   input wire logic generator_enable_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   // access that hits a mapped register
   logic hit;
   logic g;
   assign hit = (sfr_i.wr | sfr_i.rd)
      & (sfr_i.addr == fbg_pkg::CTRL_ADDR || sfr_i.addr == fbg_pkg::FRAC_ADDR);
   assign g = generator_enable_o;
   sequence s_rd_ctrl;
      sfr_i.rd && sfr_i.addr == fbg_pkg::CTRL_ADDR;
   endsequence
   sequence s_rd_frac;
      sfr_i.rd && sfr_i.addr == fbg_pkg::FRAC_ADDR;
   endsequence
   property p_ack;
      hit |=> sfr_ack_o;
   endproperty
   property p_noack;
      !hit |=> !sfr_ack_o;
   endproperty
   property p_idle;
      !(sfr_i.rd && hit) |=> sfr_rdata_o == fbg_pkg::UNMAPPED_READ;
   endproperty
   property p_ctrl;
      s_rd_ctrl |=> sfr_rdata_o[6:3] == 4'h0;
   endproperty
   property p_frac;
      s_rd_frac |=> sfr_rdata_o[7:6] == 2'h0;
   endproperty
   property p_en;
      sfr_i.wr && sfr_i.addr == fbg_pkg::CTRL_ADDR
         |=> g == $past(sfr_i.wdata[fbg_pkg::CTRL_EN_BIT]);
   endproperty
   property p_same;
      g [*4] |-> tx_baud_tick_o == rx_baud_tick_o;
   endproperty
   property p_pulse;
      tx_baud_tick_o |=> !tx_baud_tick_o;
   endproperty
   // a classic tick needs an overflow one cycle earlier
   property p_cause;
      tx_baud_tick_o && !g && !$past(g) && !$past(g, 2)
         |-> $past(legacy_i.t1_ovf) || $past(legacy_i.t2_ovf);
   endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   a_noack: assert property (p_noack) else $error("stray ack");
   a_idle: assert property (p_idle) else $error("stray rdata");
   a_ctrl: assert property (p_ctrl) else $error("ctrl 6..3 set");
   a_frac: assert property (p_frac) else $error("frac 7..6 set");
   a_en: assert property (p_en) else $error("enable wrong");
   a_same: assert property (p_same) else $error("tx rx differ");
   a_pulse: assert property (p_pulse) else $error("long tick");
   a_cause: assert property (p_cause) else $error("tick no ovf");
endmodule

// ---- verification/fbg_uart_model.sv ----
// partner: serial port side that counts ticks and times the bit period
`timescale 1ns/1ps
module fbg_uart_model (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // ticks
   input wire logic tx_tick_i,
   input wire logic rx_tick_i,
   // observations
   output int tx_cnt_o,
   output int rx_cnt_o,
   output int tx_per_o
);
   int cyc = 0;
   int last = 0;
   // one bit per tick, whatever made it; period kept for the bench
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (rst_i) begin
         tx_cnt_o <= 0;
         rx_cnt_o <= 0;
      end else begin
         if (tx_tick_i) begin
            tx_cnt_o <= tx_cnt_o + 1;
            tx_per_o <= cyc - last;
            last <= cyc;
         end
         if (rx_tick_i) begin
            rx_cnt_o <= rx_cnt_o + 1;
         end
      end
   end
endmodule

// ---- verification/tb.sv ----
// testbench: registers, generator and classic rate of the baud generator
`timescale 1ns/1ps
module tb;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic step = 1'b1;
   logic half = 1'b0;
   fbg_pkg::fbg_sfr_req_t req = '0;
   fbg_pkg::fbg_legacy_t leg = '0;
   logic [7:0] rdata;
   logic ack, tx, rx, gen;
   int tx_cnt, rx_cnt, tx_per;
   int err_count = 0;
   int n_tests = 0;
   // 125 MHz
   always #4 mclk = ~mclk;
   // core step every other cycle while half is set, else every cycle
   always @(posedge mclk) begin
      #1;
      step = half ? ~step : 1'b1;
   end
   fbg_top DUT (.mclk_i(mclk), .rst_i(rst), .core_step_i(step), .sfr_i(req),
      .sfr_rdata_o(rdata), .sfr_ack_o(ack), .legacy_i(leg), .tx_baud_tick_o(tx),
      .rx_baud_tick_o(rx), .generator_enable_o(gen));
   fbg_uart_model u_uart (.mclk_i(mclk), .rst_i(rst), .tx_tick_i(tx), .rx_tick_i(rx),
      .tx_cnt_o(tx_cnt), .rx_cnt_o(rx_cnt), .tx_per_o(tx_per));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one access, strobe sampled at exactly one edge
   task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge mclk);
      #1;
      req = '{addr: a, wr: w, rd: ~w, wdata: d};
      @(posedge mclk);
      #1;
      req = '0;
   endtask
   // expected value is {ack, rdata}
   task automatic rd_chk(input logic [7:0] a, input logic [8:0] e);
      acc(a, 1'b0, 8'h00);
      chk({ack, rdata}, e);
   endtask
   task automatic wait_tx(input int k);
      int t0;
      t0 = tx_cnt;
      repeat (5000) if (tx_cnt < t0 + k) @(posedge mclk);
      #1;
      // a generator that never ticks must not slip through as a stale period
      if (tx_cnt < t0 + k) begin
         chk(tx_cnt, t0 + k);
      end
   endtask
   task automatic ovf(input logic t2, input int p);
      repeat (p) begin
         leg.t1_ovf = ~t2;
         leg.t2_ovf = t2;
         @(posedge mclk);
         #1;
         leg.t1_ovf = 1'b0;
         leg.t2_ovf = 1'b0;
         @(posedge mclk);
         #1;
      end
   endtask
   task automatic t_regs();
      rd_chk(fbg_pkg::CTRL_ADDR, 9'h100);
      rd_chk(fbg_pkg::FRAC_ADDR, 9'h100);
      acc(8'h9f, 1'b1, 8'hff);
      rd_chk(8'h9f, 9'h000);
      rd_chk(fbg_pkg::CTRL_ADDR, 9'h100);
      acc(fbg_pkg::CTRL_ADDR, 1'b1, 8'h7e);
      rd_chk(fbg_pkg::CTRL_ADDR, 9'h106);
      acc(fbg_pkg::FRAC_ADDR, 1'b1, 8'hff);
      rd_chk(fbg_pkg::FRAC_ADDR, 9'h13f);
      chk(gen, 0);
      $display("register test done");
   endtask
   // classic inputs all high must not disturb the generator
   task automatic t_gen();
      leg = '1;
      acc(fbg_pkg::FRAC_ADDR, 1'b1, 8'h00);
      for (int s = 0; s < 7; s++) begin
         acc(fbg_pkg::CTRL_ADDR, 1'b1, 8'h80 | 8'(s));
         chk(gen, 1'b1);
         wait_tx(3);
         chk(tx_per, 16 << s);
      end
      rd_chk(fbg_pkg::CTRL_ADDR, 9'h186);
      chk(rx_cnt, tx_cnt);
      acc(fbg_pkg::FRAC_ADDR, 1'b1, 8'h12);
      wait_tx(3);
      chk(tx_per, 1312);
      $display("generator test done");
   endtask
   // m is {rate_double, tx select, rx select}
   task automatic leg_case(input logic [2:0] m, input logic t2, input int p, input int etx,
      input int erx);
      int n0;
      int r0;
      n0 = tx_cnt;
      r0 = rx_cnt;
      leg = {2'b00, m};
      ovf(t2, p - 1);
      chk(tx_cnt - n0, 0);
      ovf(t2, 1);
      chk(tx_cnt - n0, etx);
      chk(rx_cnt - r0, erx);
   endtask
   task automatic t_leg();
      leg = '0;
      acc(fbg_pkg::CTRL_ADDR, 1'b1, 8'h00);
      rd_chk(fbg_pkg::FRAC_ADDR, 9'h112);
      leg_case(3'b000, 1'b0, 32, 1, 1);
      leg_case(3'b100, 1'b0, 16, 1, 1);
      leg_case(3'b010, 1'b1, 16, 1, 0);
      leg_case(3'b001, 1'b1, 16, 0, 1);
      $display("classic test done");
   endtask
   // divided core clock: half the steps give twice the bit period
   task automatic t_step();
      acc(fbg_pkg::FRAC_ADDR, 1'b1, 8'h00);
      acc(fbg_pkg::CTRL_ADDR, 1'b1, 8'h80);
      half = 1'b1;
      wait_tx(3);
      chk(tx_per, 32);
      half = 1'b0;
      $display("core step test done");
   endtask
   // reset in mid-run brings both registers back to zero
   task automatic t_rst();
      @(posedge mclk);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      rst = 1'b0;
      chk(gen, 1'b0);
      rd_chk(fbg_pkg::CTRL_ADDR, 9'h100);
      rd_chk(fbg_pkg::FRAC_ADDR, 9'h100);
      $display("reset test done");
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge mclk);
      #1;
      rst = 1'b0;
      t_regs();
      t_gen();
      t_leg();
      t_step();
      t_rst();
      finish_test();
   end
   // run needs about 10400 cycles
   initial begin
      #400000;
      err_count++;
      finish_test();
   end
endmodule
bind fbg_top fbg_chk u_chk (.mclk_i, .rst_i, .core_step_i, .sfr_i, .legacy_i, .sfr_rdata_o,
   .sfr_ack_o, .tx_baud_tick_o, .rx_baud_tick_o, .generator_enable_o);
